// ==== ulpi_port_pkg.sv ====
// constants shared by the ulpi device port and its clock crossings
// assumes nothing of its surroundings; imported by name, never by wildcard
package ulpi_port_pkg;

  // ==========================================================================
  // bus shape and clock
  localparam int BUS_W          = 8;
  localparam int ULPI_CLK_MHZ   = 60;

  // ==========================================================================
  // event kinds reported toward the core, from the link
  localparam int KIND_W         = 3;
  localparam logic [2:0] KIND_TXCMD = 3'h0;
  localparam logic [2:0] KIND_DATA  = 3'h1;
  localparam logic [2:0] KIND_END   = 3'h2;
  localparam logic [2:0] KIND_ABORT = 3'h3;
  localparam logic [2:0] KIND_WAKE  = 3'h4;

  // ==========================================================================
  // word types sent by the core toward the link
  localparam int TYPE_W         = 2;
  localparam logic [1:0] TYPE_RXCMD = 2'h0;
  localparam logic [1:0] TYPE_DATA  = 2'h1;
  localparam logic [1:0] TYPE_REG   = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RXCMD_RST  = 8'h00;
  localparam logic       DIR_RST    = 1'h1;

endpackage

// ==== ulpi_cdc.sv ====
// two-flop level synchroniser and a toggle handshake for one word
// assumes both clocks run while a word is in flight
`timescale 1ns/1ps

module ulpi_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

module ulpi_hs_word #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_ready,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic              dst_valid,
  output logic      [W-1:0] dst_data,
  input  wire logic         dst_ready
);
  logic         req_r;
  logic         req_nxt;
  logic         idle_r;
  logic         idle_nxt;
  logic [W-1:0] data_r;
  logic [W-1:0] data_nxt;
  logic         ack_r;
  logic         ack_nxt;
  logic         ack_s;
  logic         req_s;

  ulpi_sync2 #(.W(1)) u_ack_sync (
    .clk   (src_clk),
    .rst_n (src_rst_n),
    .d     (ack_r),
    .q     (ack_s)
  );

  ulpi_sync2 #(.W(1)) u_req_sync (
    .clk   (dst_clk),
    .rst_n (dst_rst_n),
    .d     (req_r),
    .q     (req_s)
  );

  // ==========================================================================
  // source side: word is held until the ack toggle returns
  always_comb begin
    req_nxt  = req_r;
    idle_nxt = idle_r;
    data_nxt = data_r;
    if (idle_r && src_valid) begin
      req_nxt  = ~req_r;
      data_nxt = src_data;
      idle_nxt = 1'b0;
    end else if (!idle_r && (ack_s == req_r)) begin
      idle_nxt = 1'b1;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      req_r  <= 1'b0;
      idle_r <= 1'b1;
      data_r <= '0;
    end else begin
      req_r  <= req_nxt;
      idle_r <= idle_nxt;
      data_r <= data_nxt;
    end
  end

  assign src_ready = idle_r;

  // ==========================================================================
  // destination side: data_r is stable while req and ack differ
  assign dst_valid = req_s ^ ack_r;
  assign dst_data  = data_r;

  always_comb begin
    ack_nxt = ack_r ^ (dst_valid & dst_ready);
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end
endmodule

// ==== ulpi_sync_mode_port.sv ====
// device end of a ulpi interface in synchronous, low-power and serial modes
// assumes ulpi_clk is the interface clock this device sources and the link
// launches and samples all bus signals on it; the core runs on ref_clk
//
// How it works
// - enter synchronous mode once interface clock stable
// - source interface clock; may stop in low power
// - ignore bus one cycle after direction changes
// - direction low by default; high to send, in low power and until clock stable
// - direction and next high: receive data byte
// - next low: status byte, unless register read
// - direction held high in low-power, serial modes
// - stop during device drive aborts, releases bus
// - abort drops direction in the following cycle
// - next accepts byte; link moves on next
// - next unused in low-power and serial modes
// - low-power pins have fixed direction, own meaning
// - sync mode carries packets, registers, status
`timescale 1ns/1ps

module ulpi_sync_mode_port #(
  parameter int BUS_W = ulpi_port_pkg::BUS_W
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             ulpi_clk,
  input  wire logic             clk_stable,
  output logic                  clk_run,
  input  wire logic [BUS_W-1:0] ulpi_data_in,
  output logic      [BUS_W-1:0] ulpi_data_out,
  output logic      [BUS_W-1:0] ulpi_data_oe,
  output logic                  ulpi_dir,
  output logic                  ulpi_nxt,
  input  wire logic             ulpi_stp,
  input  wire logic             to_link_valid,
  input  wire logic [1:0]       to_link_type,
  input  wire logic             to_link_last,
  input  wire logic [BUS_W-1:0] to_link_byte,
  output logic                  to_link_ready,
  output logic                  from_link_valid,
  output logic      [2:0]       from_link_kind,
  output logic      [BUS_W-1:0] from_link_byte,
  input  wire logic             from_link_ready,
  input  wire logic             lp_req,
  input  wire logic             lp_keep_clk,
  input  wire logic [BUS_W-1:0] lp_pins,
  input  wire logic [BUS_W-1:0] lp_pin_oe,
  output logic      [BUS_W-1:0] lp_pins_in
);

  localparam int UP_W  = ulpi_port_pkg::KIND_W + BUS_W;
  localparam int DN_W  = ulpi_port_pkg::TYPE_W + 1 + BUS_W;
  localparam int CFG_W = 2 + 2 * BUS_W;

  if (BUS_W != 8) begin : g_bad_width
    $error("ulpi bus width must be 8");
  end

  typedef enum logic [5:0] {
    S_BLOCK = 6'h01,
    S_IDLE  = 6'h02,
    S_TX    = 6'h04,
    S_RX    = 6'h08,
    S_DROP  = 6'h10,
    S_LP    = 6'h20
  } state_t;

  // ==========================================================================
  // ulpi domain reset and level inputs
  logic             rst_u_n;
  logic [CFG_W-1:0] cfg_s;
  logic             clk_stable_s;
  logic             lp_req_s;
  logic [BUS_W-1:0] lp_pins_s;
  logic [BUS_W-1:0] lp_oe_s;

  ulpi_sync2 #(.W(1)) u_rst_sync (
    .clk   (ulpi_clk),
    .rst_n (resetn),
    .d     (1'b1),
    .q     (rst_u_n)
  );

  ulpi_sync2 #(.W(CFG_W)) u_cfg_sync (
    .clk   (ulpi_clk),
    .rst_n (rst_u_n),
    .d     ({clk_stable, lp_req, lp_pins, lp_pin_oe}),
    .q     (cfg_s)
  );

  assign clk_stable_s = cfg_s[CFG_W-1];
  assign lp_req_s     = cfg_s[CFG_W-2];
  assign lp_pins_s    = cfg_s[2*BUS_W-1:BUS_W];
  assign lp_oe_s      = cfg_s[BUS_W-1:0];

  // ==========================================================================
  // crossings between the core and the bus logic
  logic            up_valid;
  logic [UP_W-1:0] up_data;
  logic            up_ready;
  logic            cv_valid;
  logic [UP_W-1:0] cv_data;
  logic            cv_ready;
  logic            dn_valid;
  logic [DN_W-1:0] dn_data;
  logic            dn_ready;

  ulpi_hs_word #(.W(UP_W)) u_up (
    .src_clk   (ulpi_clk),
    .src_rst_n (rst_u_n),
    .src_valid (up_valid),
    .src_data  (up_data),
    .src_ready (up_ready),
    .dst_clk   (ref_clk),
    .dst_rst_n (resetn),
    .dst_valid (cv_valid),
    .dst_data  (cv_data),
    .dst_ready (cv_ready)
  );

  ulpi_hs_word #(.W(DN_W)) u_dn (
    .src_clk   (ref_clk),
    .src_rst_n (resetn),
    .src_valid (to_link_valid),
    .src_data  ({to_link_type, to_link_last, to_link_byte}),
    .src_ready (to_link_ready),
    .dst_clk   (ulpi_clk),
    .dst_rst_n (rst_u_n),
    .dst_valid (dn_valid),
    .dst_data  (dn_data),
    .dst_ready (dn_ready)
  );

  // ==========================================================================
  // bus state machine on the interface clock
  state_t           state_r;
  state_t           state_nxt;
  logic             dir_r;
  logic             dir_nxt;
  logic             dir_q_r;
  logic             nxt_r;
  logic             nxt_nxt;
  logic [BUS_W-1:0] dout_r;
  logic [BUS_W-1:0] dout_nxt;
  logic [BUS_W-1:0] doe_r;
  logic [BUS_W-1:0] doe_nxt;
  logic [BUS_W-1:0] rxcmd_r;
  logic [BUS_W-1:0] rxcmd_nxt;
  logic             evt_pend_r;
  logic             evt_pend_nxt;
  logic [2:0]       evt_kind_r;
  logic [2:0]       evt_kind_nxt;
  logic             lp_armed_r;
  logic             lp_armed_nxt;
  logic             turn;
  logic             accept;
  logic             can_take;
  logic [1:0]       dn_type;
  logic             dn_last;
  logic [BUS_W-1:0] dn_byte;

  assign dn_type = dn_data[DN_W-1 -: ulpi_port_pkg::TYPE_W];
  assign dn_last = dn_data[BUS_W];
  assign dn_byte = dn_data[BUS_W-1:0];

  always_comb begin
    turn         = dir_r ^ dir_q_r;
    accept       = nxt_r && !dir_r;
    can_take     = up_ready && !evt_pend_r && !nxt_r;
    state_nxt    = state_r;
    dir_nxt      = dir_r;
    nxt_nxt      = 1'b0;
    dout_nxt     = '0;
    rxcmd_nxt    = rxcmd_r;
    evt_pend_nxt = evt_pend_r;
    evt_kind_nxt = evt_kind_r;
    lp_armed_nxt = lp_armed_r | !lp_req_s;
    dn_ready     = 1'b0;
    up_valid     = 1'b0;
    up_data      = '0;

    // byte taken in the cycle next is high, events otherwise
    if (accept) begin
      up_valid = 1'b1;
      up_data  = {(state_r == S_IDLE) ? ulpi_port_pkg::KIND_TXCMD
                                      : ulpi_port_pkg::KIND_DATA, ulpi_data_in};
    end else if (evt_pend_r && up_ready) begin
      up_valid     = 1'b1;
      up_data      = {evt_kind_r, {BUS_W{1'b0}}};
      evt_pend_nxt = 1'b0;
    end

    case (state_r)
      S_BLOCK: begin
        dir_nxt = 1'b1;
        if (clk_stable_s) begin
          dir_nxt   = 1'b0;
          state_nxt = S_IDLE;
        end
      end
      S_IDLE: begin
        dir_nxt = 1'b0;
        if (accept) begin
          state_nxt = S_TX;
        end else if (!turn) begin
          if (lp_req_s && lp_armed_r) begin
            lp_armed_nxt = 1'b0;
            dir_nxt      = 1'b1;
            state_nxt    = S_LP;
          end else if (dn_valid) begin
            dir_nxt   = 1'b1;
            state_nxt = S_RX;
          end else if ((ulpi_data_in != '0) && can_take) begin
            nxt_nxt = 1'b1;
          end
        end
      end
      S_TX: begin
        if (ulpi_stp) begin
          state_nxt    = S_IDLE;
          evt_pend_nxt = 1'b1;
          evt_kind_nxt = ulpi_port_pkg::KIND_END;
        end else if (can_take) begin
          nxt_nxt = 1'b1;
        end
      end
      S_RX, S_DROP: begin
        dir_nxt = 1'b1;
        if (ulpi_stp && dir_r) begin
          dir_nxt      = 1'b0;
          state_nxt    = S_IDLE;
          evt_pend_nxt = 1'b1;
          evt_kind_nxt = ulpi_port_pkg::KIND_ABORT;
        end else if (state_r == S_DROP) begin
          dir_nxt   = 1'b0;
          state_nxt = S_IDLE;
        end else if (dir_r) begin
          dout_nxt = rxcmd_r;
          if (dn_valid) begin
            dn_ready = 1'b1;
            dout_nxt = dn_byte;
            case (dn_type)
              ulpi_port_pkg::TYPE_RXCMD: rxcmd_nxt = dn_byte;
              ulpi_port_pkg::TYPE_DATA:  nxt_nxt   = 1'b1;
              default:                   nxt_nxt   = 1'b0;
            endcase
            if (dn_last) begin
              state_nxt = S_DROP;
            end
          end
        end
      end
      S_LP: begin
        dir_nxt  = 1'b1;
        dout_nxt = lp_pins_s;
        if (ulpi_stp && dir_r) begin
          dir_nxt      = 1'b0;
          state_nxt    = S_IDLE;
          evt_pend_nxt = 1'b1;
          evt_kind_nxt = ulpi_port_pkg::KIND_WAKE;
        end
      end
      default: begin
        dir_nxt   = 1'b1;
        state_nxt = S_BLOCK;
      end
    endcase

    if (state_nxt == S_LP) begin
      nxt_nxt = 1'b0;
    end

    // drive from the cycle after the rise, release with the fall
    if (dir_nxt && dir_r) begin
      doe_nxt = (state_nxt == S_LP) ? lp_oe_s : '1;
    end else begin
      doe_nxt = '0;
    end
  end

  always_ff @(posedge ulpi_clk or negedge rst_u_n) begin
    if (!rst_u_n) begin
      state_r    <= S_BLOCK;
      dir_r      <= ulpi_port_pkg::DIR_RST;
      dir_q_r    <= ulpi_port_pkg::DIR_RST;
      nxt_r      <= 1'b0;
      dout_r     <= '0;
      doe_r      <= '0;
      rxcmd_r    <= ulpi_port_pkg::RXCMD_RST;
      evt_pend_r <= 1'b0;
      evt_kind_r <= ulpi_port_pkg::KIND_END;
      lp_armed_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      dir_r      <= dir_nxt;
      dir_q_r    <= dir_r;
      nxt_r      <= nxt_nxt;
      dout_r     <= dout_nxt;
      doe_r      <= doe_nxt;
      rxcmd_r    <= rxcmd_nxt;
      evt_pend_r <= evt_pend_nxt;
      evt_kind_r <= evt_kind_nxt;
      lp_armed_r <= lp_armed_nxt;
    end
  end

  assign ulpi_dir      = dir_r;
  assign ulpi_nxt      = nxt_r;
  assign ulpi_data_out = dout_r;
  assign ulpi_data_oe  = doe_r;

  // ==========================================================================
  // core domain: pin sampling for wake and serial inputs
  logic [BUS_W:0] pins_c;
  logic           stp_c;

  ulpi_sync2 #(.W(BUS_W+1)) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (resetn),
    .d     ({ulpi_stp, ulpi_data_in}),
    .q     (pins_c)
  );

  assign stp_c      = pins_c[BUS_W];
  assign lp_pins_in = pins_c[BUS_W-1:0];

  // ==========================================================================
  // core domain: interface clock run request
  logic clk_run_r;
  logic clk_run_nxt;
  logic wake_seen_r;
  logic wake_seen_nxt;

  always_comb begin
    wake_seen_nxt = lp_req && (wake_seen_r || stp_c);
    // stop only while low power is asked, not kept, and no wake seen
    clk_run_nxt   = !(lp_req && !lp_keep_clk && !wake_seen_nxt);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_run_r   <= 1'b1;
      wake_seen_r <= 1'b0;
    end else begin
      clk_run_r   <= clk_run_nxt;
      wake_seen_r <= wake_seen_nxt;
    end
  end

  assign clk_run = clk_run_r;

  // ==========================================================================
  // core domain: output stage for words from the link
  logic             fl_valid_r;
  logic             fl_valid_nxt;
  logic [2:0]       fl_kind_r;
  logic [2:0]       fl_kind_nxt;
  logic [BUS_W-1:0] fl_byte_r;
  logic [BUS_W-1:0] fl_byte_nxt;

  // a stalled core holds the crossing, which holds back next
  assign cv_ready = !fl_valid_r || from_link_ready;

  always_comb begin
    fl_valid_nxt = fl_valid_r && !from_link_ready;
    fl_kind_nxt  = fl_kind_r;
    fl_byte_nxt  = fl_byte_r;
    if (cv_valid && cv_ready) begin
      fl_valid_nxt = 1'b1;
      fl_kind_nxt  = cv_data[UP_W-1 -: ulpi_port_pkg::KIND_W];
      fl_byte_nxt  = cv_data[BUS_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fl_valid_r <= 1'b0;
      fl_kind_r  <= ulpi_port_pkg::KIND_TXCMD;
      fl_byte_r  <= '0;
    end else begin
      fl_valid_r <= fl_valid_nxt;
      fl_kind_r  <= fl_kind_nxt;
      fl_byte_r  <= fl_byte_nxt;
    end
  end

  assign from_link_valid = fl_valid_r;
  assign from_link_kind  = fl_kind_r;
  assign from_link_byte  = fl_byte_r;

endmodule

// ==== ulpi_port_properties.sv ====
// checker for the ulpi device port: bus ownership, next, stop and clock run
// assumes it is bound to ulpi_sync_mode_port and sees its ports only
`timescale 1ns/1ps

module ulpi_port_properties #(
  parameter int BUS_W = 8
) (
  input wire logic             ref_clk,
  input wire logic             resetn,
  input wire logic             ulpi_clk,
  input wire logic             clk_stable,
  input wire logic             clk_run,
  input wire logic [BUS_W-1:0] ulpi_data_oe,
  input wire logic             ulpi_dir,
  input wire logic             ulpi_nxt,
  input wire logic             ulpi_stp,
  input wire logic             lp_req,
  input wire logic             lp_keep_clk
);
  // ==========================================================================
  // bus ownership
  property p_block_dir;
    @(posedge ulpi_clk) disable iff (!resetn) !clk_stable |-> ulpi_dir;
  endproperty
  a_block_dir: assert property (p_block_dir) else $error("bus released early");
  property p_oe_idle;
    @(posedge ulpi_clk) disable iff (!resetn) !ulpi_dir |-> ulpi_data_oe == '0;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive while dir low");
  property p_turn_rise;
    @(posedge ulpi_clk) disable iff (!resetn) $rose(ulpi_dir) |-> ulpi_data_oe == '0;
  endproperty
  a_turn_rise: assert property (p_turn_rise) else $error("drive in turnaround");
  property p_stp_drop;
    @(posedge ulpi_clk) disable iff (!resetn) ulpi_dir && $past(ulpi_dir) && ulpi_stp |=> !ulpi_dir;
  endproperty
  a_stp_drop: assert property (p_stp_drop) else $error("dir held after stop");

  // ==========================================================================
  // next signal and clock run
  property p_nxt_rx;
    @(posedge ulpi_clk) disable iff (!resetn)
      ulpi_dir && ulpi_nxt |-> $past(ulpi_dir) && ulpi_data_oe == '1;
  endproperty
  a_nxt_rx: assert property (p_nxt_rx) else $error("rx data not driven");
  property p_nxt_tx_pulse;
    @(posedge ulpi_clk) disable iff (!resetn) !ulpi_dir && ulpi_nxt |=> !ulpi_nxt;
  endproperty
  a_nxt_tx_pulse: assert property (p_nxt_tx_pulse) else $error("nxt too long");
  property p_nxt_tx_cause;
    @(posedge ulpi_clk) disable iff (!resetn)
      !ulpi_dir && ulpi_nxt |-> !$past(ulpi_dir) && !$past(ulpi_dir, 2);
  endproperty
  a_nxt_tx_cause: assert property (p_nxt_tx_cause) else $error("turnaround taken");
  property p_clk_run;
    @(posedge ref_clk) disable iff (!resetn) !clk_run |-> $past(lp_req) && !$past(lp_keep_clk);
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock stopped outside low power");

  c_tx_nxt: cover property (@(posedge ulpi_clk) !ulpi_dir && ulpi_nxt);
  c_rx_nxt: cover property (@(posedge ulpi_clk) ulpi_dir && ulpi_nxt);
  c_abort: cover property (@(posedge ulpi_clk) ulpi_dir && ulpi_stp ##1 !ulpi_dir);
endmodule

bind ulpi_sync_mode_port ulpi_port_properties #(.BUS_W(BUS_W)) u_props (
  .ref_clk(ref_clk), .resetn(resetn), .ulpi_clk(ulpi_clk), .clk_stable(clk_stable),
  .clk_run(clk_run), .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
  .ulpi_stp(ulpi_stp), .lp_req(lp_req), .lp_keep_clk(lp_keep_clk)
);

// ==== ulpi_link_model.sv ====
// link-side model: sends transmit bytes and stop, records bytes the device drives
// assumes the bench calls one task at a time, just after a ulpi_clk edge
`timescale 1ns/1ps

module ulpi_link_model (
  input  wire logic       ulpi_clk,
  input  wire logic       ulpi_dir,
  input  wire logic       ulpi_nxt,
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  output logic      [7:0] bus,
  output logic            ulpi_stp
);
  logic [7:0] drv;
  logic       dir_q;
  logic [7:0] data_q[$];
  logic [7:0] st_q[$];

  initial begin
    drv      = 8'h00;
    ulpi_stp = 1'b0;
    dir_q    = 1'b1;
  end

  // link drives only while dir is low; released bits fall to the pull-down
  assign bus = (dev_oe & dev_out) | (~dev_oe & (ulpi_dir ? 8'h00 : drv));

  always @(posedge ulpi_clk) begin
    if (ulpi_dir && dir_q && dev_oe == 8'hFF) begin
      if (ulpi_nxt)
        data_q.push_back(bus);
      else if (st_q.size() == 0 || st_q[$] != bus)
        st_q.push_back(bus);
    end
    dir_q <= ulpi_dir;
  end

  task automatic tx3(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] b[3];
    int         k;
    b = '{b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      drv = b[i];
      k = 0;
      do begin
        @(posedge ulpi_clk);
        k++;
      end while (ulpi_nxt !== 1'b1 && k < 400);
      #1;
    end
    drv      = 8'h00;
    ulpi_stp = 1'b1;
    @(posedge ulpi_clk);
    #1;
    ulpi_stp = 1'b0;
  endtask

  // stop while the device drives data; also wakes from low power when held
  task automatic stop(input logic hold);
    int k;
    k = 0;
    while (!(ulpi_dir === 1'b1 && (hold || dev_oe === 8'hFF)) && k < 400) begin
      @(posedge ulpi_clk);
      #1;
      k++;
    end
    ulpi_stp = 1'b1;
    do begin
      @(posedge ulpi_clk);
      #1;
      k++;
    end while (hold && ulpi_dir !== 1'b0 && k < 800);
    ulpi_stp = 1'b0;
  endtask
endmodule

// ==== test_ulpi_sync_mode_port.sv ====
// bench for the ulpi device port: boot, receive, transmit, abort and low power
// assumes the link model plays the bus side and the bench plays the core on ref_clk
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module test_ulpi_sync_mode_port;
  logic        ref_clk, resetn, ulpi_clk, clk_stable, clk_run, ulpi_dir, ulpi_nxt, ulpi_stp;
  logic        to_link_valid, to_link_last, to_link_ready, from_link_valid, from_link_ready;
  logic        lp_req, lp_keep_clk;
  logic [1:0]  to_link_type;
  logic [2:0]  from_link_kind, stall_cnt;
  logic [7:0]  data_in, data_out, data_oe, to_link_byte, from_link_byte;
  logic [7:0]  lp_pins, lp_pin_oe, lp_pins_in;
  logic [10:0] ev_q[$];
  int          bad_count, n_tests;

  ulpi_sync_mode_port #(.BUS_W(8)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .ulpi_clk(ulpi_clk), .clk_stable(clk_stable),
    .clk_run(clk_run), .ulpi_data_in(data_in), .ulpi_data_out(data_out),
    .ulpi_data_oe(data_oe), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp),
    .to_link_valid(to_link_valid), .to_link_type(to_link_type), .to_link_last(to_link_last),
    .to_link_byte(to_link_byte), .to_link_ready(to_link_ready),
    .from_link_valid(from_link_valid), .from_link_kind(from_link_kind),
    .from_link_byte(from_link_byte), .from_link_ready(from_link_ready), .lp_req(lp_req),
    .lp_keep_clk(lp_keep_clk), .lp_pins(lp_pins), .lp_pin_oe(lp_pin_oe), .lp_pins_in(lp_pins_in)
  );
  ulpi_link_model u_link (.ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .dev_out(data_out), .dev_oe(data_oe), .bus(data_in), .ulpi_stp(ulpi_stp));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    ulpi_clk = 1'b0;
    #3;
    forever #7.5 ulpi_clk = ~ulpi_clk;
  end

  // core accepts events but stalls one cycle in eight
  always @(negedge ref_clk) begin
    stall_cnt <= stall_cnt + 3'h1;
    from_link_ready <= (stall_cnt != 3'h7);
  end
  always @(posedge ref_clk)
    if (from_link_valid === 1'b1 && from_link_ready === 1'b1)
      ev_q.push_back({from_link_kind, from_link_byte});

  task automatic push(input logic [1:0] ty, input logic [7:0] b, input logic lst);
    int k;
    @(negedge ref_clk);
    to_link_valid = 1'b1;
    to_link_type  = ty;
    to_link_byte  = b;
    to_link_last  = lst;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (to_link_ready !== 1'b1 && k < 300);
    @(negedge ref_clk);
    to_link_valid = 1'b0;
  endtask

  task automatic ev(input logic [2:0] kd, input logic [7:0] b);
    logic [10:0] got;
    for (int k = 0; k < 300 && ev_q.size() == 0; k++)
      @(posedge ref_clk);
    got = (ev_q.size() > 0) ? ev_q.pop_front() : 'x;
    `CHK("link_event", {kd, b}, got)
  endtask

  task automatic wdir(input logic v);
    for (int k = 0; k < 300 && ulpi_dir !== v; k++) begin
      @(posedge ulpi_clk);
      #1;
    end
  endtask

  task automatic t_boot();
    repeat (8) @(posedge ulpi_clk);
    #1;
    `CHK("dir_block", 1'b1, ulpi_dir)
    @(negedge ref_clk);
    clk_stable = 1'b1;
    wdir(1'b0);
    repeat (2) @(posedge ulpi_clk);
    #1;
    `CHK("dir_idle", 1'b0, ulpi_dir)
    `CHK("oe_idle", 8'h00, data_oe)
    $display("t_boot done");
  endtask

  task automatic t_rx();
    u_link.data_q.delete();
    u_link.st_q.delete();
    push(ulpi_port_pkg::TYPE_RXCMD, 8'h5A, 1'b0);
    push(ulpi_port_pkg::TYPE_REG, 8'hC3, 1'b0);
    push(ulpi_port_pkg::TYPE_DATA, 8'h11, 1'b0);
    push(ulpi_port_pkg::TYPE_DATA, 8'h22, 1'b1);
    wdir(1'b0);
    `CHK("rx_count", 2, u_link.data_q.size())
    `CHK("rx_data0", 8'h11, u_link.data_q[0])
    `CHK("rx_data1", 8'h22, u_link.data_q[1])
    `CHK("rx_status", 8'h5A, u_link.st_q[0])
    `CHK("rx_reg", 8'hC3, u_link.st_q[1])
    $display("t_rx done");
  endtask

  task automatic t_tx();
    u_link.tx3(8'h41, 8'h12, 8'h34);
    ev(ulpi_port_pkg::KIND_TXCMD, 8'h41);
    ev(ulpi_port_pkg::KIND_DATA, 8'h12);
    ev(ulpi_port_pkg::KIND_DATA, 8'h34);
    ev(ulpi_port_pkg::KIND_END, 8'h00);
    $display("t_tx done");
  endtask

  task automatic t_abort();
    push(ulpi_port_pkg::TYPE_DATA, 8'h77, 1'b0);
    u_link.stop(1'b0);
    `CHK("dir_abort", 1'b0, ulpi_dir)
    `CHK("oe_abort", 8'h00, data_oe)
    ev(ulpi_port_pkg::KIND_ABORT, 8'h00);
    $display("t_abort done");
  endtask

  task automatic t_lp();
    @(negedge ref_clk);
    lp_pins   = 8'hA5;
    lp_pin_oe = 8'h0F;
    lp_req    = 1'b1;
    wdir(1'b1);
    repeat (8) @(posedge ulpi_clk);
    #1;
    `CHK("lp_dir", 1'b1, ulpi_dir)
    `CHK("lp_oe", 8'h0F, data_oe)
    `CHK("lp_out", 8'hA5, data_out)
    `CHK("lp_nxt", 1'b0, ulpi_nxt)
    `CHK("lp_in", 8'h05, lp_pins_in)
    `CHK("clk_stop", 1'b0, clk_run)
    @(negedge ref_clk);
    lp_keep_clk = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("clk_keep", 1'b1, clk_run)
    lp_keep_clk = 1'b0;
    u_link.stop(1'b1);
    `CHK("dir_wake", 1'b0, ulpi_dir)
    ev(ulpi_port_pkg::KIND_WAKE, 8'h00);
    @(negedge ref_clk);
    `CHK("clk_wake", 1'b1, clk_run)
    lp_req = 1'b0;
    repeat (10) @(negedge ref_clk);
    `CHK("clk_back", 1'b1, clk_run)
    $display("t_lp done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end

  initial begin
    {resetn, clk_stable, lp_req, lp_keep_clk, to_link_valid, to_link_last} = 6'h00;
    {to_link_type, to_link_byte, lp_pins, lp_pin_oe} = 26'h0;
    {from_link_ready, stall_cnt, bad_count, n_tests} = '0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    t_boot();
    t_rx();
    t_tx();
    t_abort();
    t_lp();
    wrap_up();
  end
endmodule
